// ---- shared/lpmc_consts.vh ----
`ifndef LPMC_CONSTS_VH
`define LPMC_CONSTS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define LPMC_OFF_CTRL     12'h000
`define LPMC_OFF_PRESC    12'h004
`define LPMC_OFF_AHB_EN   12'h008
`define LPMC_OFF_APBL_EN  12'h00C
`define LPMC_OFF_APBH_EN  12'h010
`define LPMC_OFF_STATUS   12'h014
`define LPMC_OFF_IRQ_ST   12'h018
`define LPMC_OFF_IRQ_MSK  12'h01C

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define LPMC_CTRL_SOE     0
`define LPMC_CTRL_DEEP    1
`define LPMC_CTRL_PDS     2
`define LPMC_CTRL_LPR     3

// ------------------------------------------------------------
// Prescaler register fields (divide ratio = field + 1)
// ------------------------------------------------------------
`define LPMC_PRE_SYS_LSB  0
`define LPMC_PRE_AHB_LSB  4
`define LPMC_PRE_APBL_LSB 8
`define LPMC_PRE_APBH_LSB 12
`define LPMC_PRE_W        4

// ------------------------------------------------------------
// Mode encodings, shown in the status register
// ------------------------------------------------------------
`define LPMC_MODE_RUN     3'h0
`define LPMC_MODE_SLEEP   3'h1
`define LPMC_MODE_SOE     3'h2
`define LPMC_MODE_STOP    3'h3
`define LPMC_MODE_STBY    3'h4

// ------------------------------------------------------------
// Interrupt status bits
// ------------------------------------------------------------
`define LPMC_IRQ_SLEEP    0
`define LPMC_IRQ_STOP     1
`define LPMC_IRQ_STBY     2
`define LPMC_IRQ_WAKE     3
`define LPMC_IRQ_W        4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define LPMC_RST_CTRL     32'h00000000
`define LPMC_RST_PRESC    32'h00000000
`define LPMC_RST_EN       32'hFFFFFFFF

`endif

// ---- logic/lpmc_ctrl.v ----
// Behaviour
// - After any reset the block is in Run with the CPU clock running.
// - Wait instruction with deep select and return select clear enters Sleep at once.
// - With return select set, Sleep is entered when the last ISR returns.
// - Return-sleep needs the interrupt wait, deep clear, return set; interrupts end it.
// - Interrupt-wait Sleep ends on any interrupt taken by the interrupt controller.
// - Event-wait Sleep ends on the first event: local interrupt or event line.
// - Sleep gates only the CPU clock; all else and the regulator stay on.
// - Leaving Sleep adds no latency cycle.
// - Deep set, power-down clear gives Stop; clocks, oscillators off; event line wakes.
// - Deep and power-down set give Standby: core domain, oscillators, regulator off.
// - System, AHB and both APB clocks have programmable prescalers in Run.
// - Each peripheral bus clock can be gated at any time by an enable bit.
`timescale 1ns/10ps
`include "lpmc_consts.vh"

module lpmc_ctrl #(
  parameter NPER = 32
) (
  input  wire            pclk,
  input  wire            presetn,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [11:0]     paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output wire            pready,
  output wire            pslverr,
  input  wire            wait_for_interrupt_instr,
  input  wire            wait_for_event_instr,
  input  wire            isr_return_last,
  input  wire            irq_acknowledged,
  input  wire            local_irq_event,
  input  wire [15:0]     external_event_lines,
  output wire            cpu_clock_en,
  output reg             system_clock_en,
  output reg             ahb_clock_en,
  output reg             apb_low_clock_en,
  output reg             apb_high_clock_en,
  output wire [NPER-1:0] ahb_periph_clock_en,
  output wire [NPER-1:0] apb_low_periph_clock_en,
  output wire [NPER-1:0] apb_high_periph_clock_en,
  output wire            internal_fast_oscillator_en,
  output wire            external_fast_oscillator_en,
  output wire            regulator_on,
  output wire            regulator_low_power,
  output wire            core_domain_power_on,
  output wire [2:0]      power_mode,
  output wire            irq
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg  [3:0]             ctrl_q;
  reg  [15:0]            presc_q;
  reg  [NPER-1:0]        ahb_en_q;
  reg  [NPER-1:0]        apbl_en_q;
  reg  [NPER-1:0]        apbh_en_q;
  reg  [`LPMC_IRQ_W-1:0] irq_st_q;
  reg  [`LPMC_IRQ_W-1:0] irq_msk_q;
  reg  [2:0]             mode_q;
  reg  [2:0]             mode_d;
  reg                    via_event_q;
  reg                    via_event_d;
  reg  [15:0]            ext_s1_q;
  reg  [15:0]            ext_s2_q;
  reg  [15:0]            ext_s3_q;
  reg  [3:0]             cnt_sys_q;
  reg  [3:0]             cnt_ahb_q;
  reg  [3:0]             cnt_apbl_q;
  reg  [3:0]             cnt_apbh_q;
  reg  [15:0]            ext_lvl_q;
  reg                    soe_arm_q;
  reg                    soe_arm_d;

  wire                   wr_en;
  wire                   rd_en;
  wire                   sel_ok;
  wire                   ext_evt;
  wire                   any_wait;
  wire                   sleep_wake;
  wire                   stop_wake;
  wire [`LPMC_IRQ_W-1:0] irq_set;
  wire [`LPMC_IRQ_W-1:0] irq_clr;

  localparam [2:0] ST_RUN   = `LPMC_MODE_RUN;
  localparam [2:0] ST_SLEEP = `LPMC_MODE_SLEEP;
  localparam [2:0] ST_SOE   = `LPMC_MODE_SOE;
  localparam [2:0] ST_STOP  = `LPMC_MODE_STOP;
  localparam [2:0] ST_STBY  = `LPMC_MODE_STBY;

  // Reset values at full word width, cut to each register below
  localparam [31:0] RST_CTRL  = `LPMC_RST_CTRL;
  localparam [31:0] RST_PRESC = `LPMC_RST_PRESC;
  localparam [31:0] RST_EN    = `LPMC_RST_EN;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function decoded;
    input [11:0] addr;
    begin
      decoded = (addr[1:0] == 2'h0) && (addr <= `LPMC_OFF_IRQ_MSK);
    end
  endfunction

  // Counter wraps at the ratio and flags one cycle per period
  function [3:0] div_next;
    input [3:0] cnt;
    input [3:0] ratio;
    begin
      div_next = (cnt >= ratio) ? 4'h0 : cnt + 4'h1;
    end
  endfunction

  // ------------------------------------------------------------
  // APB slave: zero wait state, error on unmapped address
  // ------------------------------------------------------------
  assign sel_ok  = decoded(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~sel_ok;
  assign wr_en   = psel & penable & pwrite & sel_ok;
  assign rd_en   = psel & ~penable & ~pwrite;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= RST_CTRL[3:0];
      presc_q   <= RST_PRESC[15:0];
      ahb_en_q  <= RST_EN[NPER-1:0];
      apbl_en_q <= RST_EN[NPER-1:0];
      apbh_en_q <= RST_EN[NPER-1:0];
      irq_msk_q <= {`LPMC_IRQ_W{1'b0}};
    end else if (wr_en) begin
      case (paddr)
        `LPMC_OFF_CTRL:    ctrl_q    <= pwdata[3:0];
        `LPMC_OFF_PRESC:   presc_q   <= pwdata[15:0];
        `LPMC_OFF_AHB_EN:  ahb_en_q  <= pwdata[NPER-1:0];
        `LPMC_OFF_APBL_EN: apbl_en_q <= pwdata[NPER-1:0];
        `LPMC_OFF_APBH_EN: apbh_en_q <= pwdata[NPER-1:0];
        `LPMC_OFF_IRQ_MSK: irq_msk_q <= pwdata[`LPMC_IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read data registered in the setup cycle so it stands in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      case (paddr)
        `LPMC_OFF_CTRL:    prdata <= {28'h0000000, ctrl_q};
        `LPMC_OFF_PRESC:   prdata <= {16'h0000, presc_q};
        `LPMC_OFF_AHB_EN:  prdata <= ahb_en_q;
        `LPMC_OFF_APBL_EN: prdata <= apbl_en_q;
        `LPMC_OFF_APBH_EN: prdata <= apbh_en_q;
        `LPMC_OFF_STATUS:  prdata <= {28'h0000000, via_event_q, mode_q};
        `LPMC_OFF_IRQ_ST:  prdata <= {28'h0000000, irq_st_q};
        `LPMC_OFF_IRQ_MSK: prdata <= {28'h0000000, irq_msk_q};
        default:           prdata <= 32'h00000000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // External event line synchroniser
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_q <= 16'h0000;
      ext_s2_q <= 16'h0000;
      ext_s3_q <= 16'h0000;
    end else begin
      ext_s1_q <= external_event_lines;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // Level accepted once the second and third stages agree; an event is a
  // rise of that level, so a glitch seen by one stage only is ignored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_lvl_q <= 16'h0000;
    end else begin
      ext_lvl_q <= (ext_s2_q & ext_s3_q) | (ext_lvl_q & (ext_s2_q | ext_s3_q));
    end
  end

  assign ext_evt = |(ext_s2_q & ext_s3_q & ~ext_lvl_q);

  // ------------------------------------------------------------
  // Return-sleep arming
  // ------------------------------------------------------------
  // Only an interrupt wait arms return-sleep; once armed, every return
  // from the last ISR sleeps again until software drops the select or sets deep
  always @* begin
    soe_arm_d = soe_arm_q;
    if (!ctrl_q[`LPMC_CTRL_SOE] || ctrl_q[`LPMC_CTRL_DEEP]) begin
      soe_arm_d = 1'b0;
    end else if ((mode_q == ST_RUN) && wait_for_interrupt_instr) begin
      soe_arm_d = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soe_arm_q <= 1'b0;
    end else begin
      soe_arm_q <= soe_arm_d;
    end
  end

  // ------------------------------------------------------------
  // Mode state machine
  // ------------------------------------------------------------
  assign any_wait   = wait_for_interrupt_instr | wait_for_event_instr;
  // Event-wait exits on local interrupt or event line; interrupt-wait on ack
  assign sleep_wake = via_event_q ? (local_irq_event | ext_evt)
                                  : irq_acknowledged;
  assign stop_wake  = ext_evt;

  always @* begin
    mode_d      = mode_q;
    via_event_d = via_event_q;
    case (mode_q)
      ST_RUN: begin
        if (any_wait && ctrl_q[`LPMC_CTRL_DEEP]) begin
          via_event_d = wait_for_event_instr;
          mode_d = ctrl_q[`LPMC_CTRL_PDS] ? ST_STBY : ST_STOP;
        end else if (any_wait && !ctrl_q[`LPMC_CTRL_SOE]) begin
          via_event_d = wait_for_event_instr;
          mode_d = ST_SLEEP;
        end else if (isr_return_last && soe_arm_q && ctrl_q[`LPMC_CTRL_SOE]
                     && !ctrl_q[`LPMC_CTRL_DEEP]) begin
          via_event_d = 1'b0;
          mode_d = ST_SOE;
        end
      end
      ST_SLEEP: begin
        if (sleep_wake) begin
          mode_d = ST_RUN;
        end
      end
      ST_SOE: begin
        if (irq_acknowledged) begin
          mode_d = ST_RUN;
        end
      end
      ST_STOP: begin
        if (stop_wake) begin
          mode_d = ST_RUN;
        end
      end
      ST_STBY: begin
        // Left only by a reset of the core domain
        mode_d = ST_STBY;
      end
      default: begin
        mode_d = ST_RUN;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q      <= ST_RUN;
      via_event_q <= 1'b0;
    end else begin
      mode_q      <= mode_d;
      via_event_q <= via_event_d;
    end
  end

  // ------------------------------------------------------------
  // Interrupt status
  // ------------------------------------------------------------
  assign irq_set[`LPMC_IRQ_SLEEP] = (mode_q == ST_RUN) &&
                                    ((mode_d == ST_SLEEP) || (mode_d == ST_SOE));
  assign irq_set[`LPMC_IRQ_STOP]  = (mode_q == ST_RUN) && (mode_d == ST_STOP);
  assign irq_set[`LPMC_IRQ_STBY]  = (mode_q == ST_RUN) && (mode_d == ST_STBY);
  assign irq_set[`LPMC_IRQ_WAKE]  = (mode_q != ST_RUN) && (mode_d == ST_RUN);
  assign irq_clr = (wr_en && paddr == `LPMC_OFF_IRQ_ST) ?
                   pwdata[`LPMC_IRQ_W-1:0] : {`LPMC_IRQ_W{1'b0}};

  // Set wins over a clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_q <= {`LPMC_IRQ_W{1'b0}};
    end else begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_st_q & irq_msk_q);

  // ------------------------------------------------------------
  // Run-mode clock prescalers (one-cycle enable pulses)
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_sys_q         <= 4'h0;
      cnt_ahb_q         <= 4'h0;
      cnt_apbl_q        <= 4'h0;
      cnt_apbh_q        <= 4'h0;
      system_clock_en   <= 1'b0;
      ahb_clock_en      <= 1'b0;
      apb_low_clock_en  <= 1'b0;
      apb_high_clock_en <= 1'b0;
    end else begin
      cnt_sys_q  <= div_next(cnt_sys_q, presc_q[`LPMC_PRE_SYS_LSB +: `LPMC_PRE_W]);
      cnt_ahb_q  <= div_next(cnt_ahb_q, presc_q[`LPMC_PRE_AHB_LSB +: `LPMC_PRE_W]);
      cnt_apbl_q <= div_next(cnt_apbl_q, presc_q[`LPMC_PRE_APBL_LSB +: `LPMC_PRE_W]);
      cnt_apbh_q <= div_next(cnt_apbh_q, presc_q[`LPMC_PRE_APBH_LSB +: `LPMC_PRE_W]);
      // Stop and Standby halt every core-domain clock
      system_clock_en   <= (mode_d != ST_STOP) && (mode_d != ST_STBY) &&
                           (cnt_sys_q == 4'h0);
      ahb_clock_en      <= (mode_d != ST_STOP) && (mode_d != ST_STBY) &&
                           (cnt_ahb_q == 4'h0);
      apb_low_clock_en  <= (mode_d != ST_STOP) && (mode_d != ST_STBY) &&
                           (cnt_apbl_q == 4'h0);
      apb_high_clock_en <= (mode_d != ST_STOP) && (mode_d != ST_STBY) &&
                           (cnt_apbh_q == 4'h0);
    end
  end

  // ------------------------------------------------------------
  // Clock and power outputs
  // ------------------------------------------------------------
  // CPU clock gate follows the state directly so wakeup costs no cycle
  assign cpu_clock_en = (mode_q == ST_RUN);
  // Sleep leaves peripheral gates alone; software should trim them first
  assign ahb_periph_clock_en      = (ahb_clock_en) ? ahb_en_q : {NPER{1'b0}};
  assign apb_low_periph_clock_en  = (apb_low_clock_en) ? apbl_en_q : {NPER{1'b0}};
  assign apb_high_periph_clock_en = (apb_high_clock_en) ? apbh_en_q : {NPER{1'b0}};
  assign internal_fast_oscillator_en = (mode_q != ST_STOP) && (mode_q != ST_STBY);
  assign external_fast_oscillator_en = (mode_q != ST_STOP) && (mode_q != ST_STBY);
  assign regulator_on         = (mode_q != ST_STBY);
  assign regulator_low_power  = (mode_q == ST_STOP) && ctrl_q[`LPMC_CTRL_LPR];
  assign core_domain_power_on = (mode_q != ST_STBY);
  assign power_mode           = mode_q;

endmodule

// ---- verif/lpmc_checker.sv ----
`timescale 1ns/10ps
`include "lpmc_consts.vh"
module lpmc_checker #(
  parameter NPER = 32
) (
  input wire            pclk,
  input wire            presetn,
  input wire            irq_acknowledged,
  input wire [15:0]     external_event_lines,
  input wire            cpu_clock_en,
  input wire            system_clock_en,
  input wire            ahb_clock_en,
  input wire [NPER-1:0] ahb_periph_clock_en,
  input wire            internal_fast_oscillator_en,
  input wire            external_fast_oscillator_en,
  input wire            regulator_on,
  input wire            regulator_low_power,
  input wire            core_domain_power_on,
  input wire [2:0]      power_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire osc_on  = internal_fast_oscillator_en && external_fast_oscillator_en;
  wire osc_off = !internal_fast_oscillator_en && !external_fast_oscillator_en;
  wire slp     = power_mode == `LPMC_MODE_SLEEP || power_mode == `LPMC_MODE_SOE;

  a_reset_run: assert property ($rose(presetn) |-> power_mode == `LPMC_MODE_RUN)
    else $error("mode after reset is not Run");
  a_cpu_clock: assert property (cpu_clock_en == (power_mode == `LPMC_MODE_RUN))
    else $error("cpu clock enable disagrees with mode");
  a_sleep_keep: assert property (slp |-> osc_on && regulator_on && core_domain_power_on)
    else $error("sleep stopped more than the cpu clock");
  a_stop_state: assert property (power_mode == `LPMC_MODE_STOP |->
    osc_off && regulator_on && !system_clock_en && !ahb_clock_en)
    else $error("stop state outputs wrong");
  a_stop_wake: assert property (power_mode == `LPMC_MODE_STOP &&
    (external_event_lines & ~$past(external_event_lines)) != 16'h0000 |->
    ##[1:8] power_mode == `LPMC_MODE_RUN)
    else $error("event line edge did not end stop");
  a_standby_off: assert property (power_mode == `LPMC_MODE_STBY |->
    osc_off && !regulator_on && !core_domain_power_on)
    else $error("standby left power on");
  a_standby_hold: assert property (power_mode == `LPMC_MODE_STBY |=>
    power_mode == `LPMC_MODE_STBY)
    else $error("standby left without reset");
  a_return_hold: assert property (power_mode == `LPMC_MODE_SOE && !irq_acknowledged |=>
    power_mode == `LPMC_MODE_SOE)
    else $error("return sleep ended without interrupt");
  a_return_wake: assert property (power_mode == `LPMC_MODE_SOE && irq_acknowledged |=>
    power_mode == `LPMC_MODE_RUN && cpu_clock_en)
    else $error("return sleep wake was late");
  a_ahb_gate: assert property (ahb_periph_clock_en != 0 |-> ahb_clock_en)
    else $error("peripheral clock without bus clock");
endmodule

// ---- verif/lpmc_core_model.sv ----
`timescale 1ns/10ps
module lpmc_core_model (
  input  wire        pclk,
  output wire        wait_for_interrupt_instr,
  output wire        wait_for_event_instr,
  output wire        isr_return_last,
  output wire        irq_acknowledged,
  output wire        local_irq_event,
  output reg  [15:0] external_event_lines
);
  reg [4:0] pulse_q = 5'h00;
  initial external_event_lines = 16'h0000;
  assign {local_irq_event, irq_acknowledged, isr_return_last} = pulse_q[4:2];
  assign {wait_for_event_instr, wait_for_interrupt_instr} = pulse_q[1:0];
  // Kinds: 0 int wait, 1 event wait, 2 ISR return, 3 acknowledge, 4 local event
  task pulse(input integer k);
    begin
      @(posedge pclk);
      pulse_q <= 5'h01 << k;
      @(posedge pclk);
      pulse_q <= 5'h00;
    end
  endtask
  // Held long enough to pass the pin synchroniser before falling
  task ext(input [3:0] b);
    begin
      @(posedge pclk);
      external_event_lines <= 16'h0001 << b;
      repeat (6) @(posedge pclk);
      external_event_lines <= 16'h0000;
    end
  endtask
endmodule

// ---- verif/low_power_mode_control_tb_top.sv ----
`timescale 1ns/10ps
`include "lpmc_consts.vh"
module low_power_mode_control_tb_top;
  localparam NPER = 32;
  reg             pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg  [11:0]     paddr = 12'h000;
  reg  [31:0]     pwdata = 32'h0, rnd = 32'hFA0F7433, g, exp_q[$];
  integer         i, failures = 0, num_checks = 0;
  wire [31:0]     prdata;
  wire [NPER-1:0] ahb_periph_clock_en, apb_low_periph_clock_en, apb_high_periph_clock_en;
  wire [15:0]     external_event_lines;
  wire [2:0]      power_mode;
  wire pready, pslverr, wait_for_interrupt_instr, wait_for_event_instr, isr_return_last;
  wire irq_acknowledged, local_irq_event, cpu_clock_en, system_clock_en, ahb_clock_en;
  wire apb_low_clock_en, apb_high_clock_en, internal_fast_oscillator_en, irq;
  wire external_fast_oscillator_en, regulator_on, regulator_low_power, core_domain_power_on;
  wire [3:0] bus_en = {apb_high_clock_en, apb_low_clock_en, ahb_clock_en, system_clock_en};

  lpmc_ctrl #(.NPER(NPER)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wait_for_interrupt_instr(wait_for_interrupt_instr),
    .wait_for_event_instr(wait_for_event_instr), .isr_return_last(isr_return_last),
    .irq_acknowledged(irq_acknowledged), .local_irq_event(local_irq_event),
    .external_event_lines(external_event_lines), .cpu_clock_en(cpu_clock_en),
    .system_clock_en(system_clock_en), .ahb_clock_en(ahb_clock_en),
    .apb_low_clock_en(apb_low_clock_en), .apb_high_clock_en(apb_high_clock_en),
    .ahb_periph_clock_en(ahb_periph_clock_en),
    .apb_low_periph_clock_en(apb_low_periph_clock_en),
    .apb_high_periph_clock_en(apb_high_periph_clock_en),
    .internal_fast_oscillator_en(internal_fast_oscillator_en),
    .external_fast_oscillator_en(external_fast_oscillator_en),
    .regulator_on(regulator_on), .regulator_low_power(regulator_low_power),
    .core_domain_power_on(core_domain_power_on), .power_mode(power_mode), .irq(irq));
  lpmc_core_model core (.pclk(pclk), .wait_for_interrupt_instr(wait_for_interrupt_instr),
    .wait_for_event_instr(wait_for_event_instr), .isr_return_last(isr_return_last),
    .irq_acknowledged(irq_acknowledged), .local_irq_event(local_irq_event),
    .external_event_lines(external_event_lines));

  always #2.5 pclk = ~pclk;

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [31:0] e, input [31:0] a);
    begin
      num_checks = num_checks + 1;
      if (a !== e) begin
        failures = failures + 1;
        $display("unexpected at %0t: got %h, expected %h", $time, a, e);
      end
    end
  endtask
  // For a read, d is the expected data noted for the watcher
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      if (!w) exp_q.push_back(d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= w ? d : 32'h0;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Unmapped offsets answer with an error in the access phase
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1) begin
      chk((paddr > `LPMC_OFF_IRQ_MSK) ? 32'h1 : 32'h0, pslverr);
      if (!pwrite && exp_q.size() > 0)
        chk(exp_q.pop_front(), prdata);
    end
  task mode(input [2:0] m);
    begin
      @(negedge pclk);
      chk(m, power_mode);
    end
  endtask
  // Cycles between two enable pulses of one bus clock
  task per(input integer b, input integer e);
    integer n;
    begin
      n = 0;
      @(negedge pclk);
      while (bus_en[b] !== 1'b1 && n < 40) begin
        n = n + 1;
        @(negedge pclk);
      end
      n = 1;
      @(negedge pclk);
      while (bus_en[b] !== 1'b1 && n < 40) begin
        n = n + 1;
        @(negedge pclk);
      end
      chk(e, n);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  initial begin
    #60000;
    failures = failures + 1;
    print_verdict;
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 9; i = i + 1)
      apb(0, 12'(i * 4), (i > 1 && i < 5) ? 32'hFFFFFFFF : 32'h0);
    g = lfsr(rnd);
    apb(1, `LPMC_OFF_AHB_EN, g);
    apb(1, `LPMC_OFF_APBH_EN, ~g);
    @(negedge pclk);
    chk(g, ahb_periph_clock_en);
    chk(~g, apb_high_periph_clock_en);
    rnd = lfsr(g);
    apb(1, `LPMC_OFF_PRESC, {16'h0, rnd[15:0]});
    apb(0, `LPMC_OFF_PRESC, {16'h0, rnd[15:0]});
    repeat (40) @(negedge pclk);
    for (i = 0; i < 4; i = i + 1)
      per(i, rnd[4*i +: 4] + 1);
    apb(1, `LPMC_OFF_PRESC, 32'h0);
    // Gate an unused bus before waiting; the other bus must keep running
    apb(1, `LPMC_OFF_APBL_EN, 32'h0);
    apb(1, `LPMC_OFF_IRQ_MSK, 32'h1);
    core.pulse(0);
    mode(`LPMC_MODE_SLEEP);
    chk(0, apb_low_periph_clock_en);
    chk(~g, apb_high_periph_clock_en);
    core.pulse(4);
    mode(`LPMC_MODE_SLEEP);
    chk(1, irq);
    core.pulse(3);
    mode(`LPMC_MODE_RUN);
    apb(0, `LPMC_OFF_IRQ_ST, 32'h9);
    apb(1, `LPMC_OFF_IRQ_ST, 32'h9);
    apb(1, `LPMC_OFF_IRQ_MSK, 32'h0);
    @(negedge pclk);
    chk(0, irq);
    for (i = 0; i < 2; i = i + 1) begin
      core.pulse(1);
      mode(`LPMC_MODE_SLEEP);
      apb(0, `LPMC_OFF_STATUS, 32'h9);
      chk(0, irq);
      if (i == 0) core.pulse(4);
      else core.ext(4'h5);
      mode(`LPMC_MODE_RUN);
      apb(1, `LPMC_OFF_IRQ_ST, 32'hF);
    end
    apb(1, `LPMC_OFF_CTRL, 32'h1);
    // A return from the last ISR before any interrupt wait must not sleep
    core.pulse(2);
    mode(`LPMC_MODE_RUN);
    core.pulse(0);
    mode(`LPMC_MODE_RUN);
    core.pulse(2);
    mode(`LPMC_MODE_SOE);
    core.pulse(4);
    core.ext(4'h2);
    mode(`LPMC_MODE_SOE);
    core.pulse(3);
    mode(`LPMC_MODE_RUN);
    core.pulse(2);
    mode(`LPMC_MODE_SOE);
    core.pulse(3);
    mode(`LPMC_MODE_RUN);
    apb(1, `LPMC_OFF_IRQ_ST, 32'hF);
    apb(1, `LPMC_OFF_CTRL, 32'hA);
    core.pulse(1);
    mode(`LPMC_MODE_STOP);
    chk(1, regulator_low_power);
    core.ext(4'h0);
    mode(`LPMC_MODE_RUN);
    apb(0, `LPMC_OFF_IRQ_ST, 32'hA);
    apb(1, `LPMC_OFF_CTRL, 32'h6);
    core.pulse(0);
    mode(`LPMC_MODE_STBY);
    core.pulse(3);
    mode(`LPMC_MODE_STBY);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    mode(`LPMC_MODE_RUN);
    apb(0, `LPMC_OFF_CTRL, 32'h0);
    print_verdict;
  end
endmodule

bind lpmc_ctrl lpmc_checker #(.NPER(NPER)) chk_i (.pclk(pclk), .presetn(presetn),
  .irq_acknowledged(irq_acknowledged), .external_event_lines(external_event_lines),
  .cpu_clock_en(cpu_clock_en), .system_clock_en(system_clock_en),
  .ahb_clock_en(ahb_clock_en), .ahb_periph_clock_en(ahb_periph_clock_en),
  .internal_fast_oscillator_en(internal_fast_oscillator_en),
  .external_fast_oscillator_en(external_fast_oscillator_en),
  .regulator_on(regulator_on), .regulator_low_power(regulator_low_power),
  .core_domain_power_on(core_domain_power_on), .power_mode(power_mode));
